// ==== bench/config_controller.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// external controller on the three-wire load port
module config_controller (
  // pacing clock
  input  wire logic aclk,
  // serial pins
  output logic      shift_clock,
  output logic      shift_data,
  output logic      commit_strobe
);
  initial begin
    shift_clock = 1'b0;
    shift_data = 1'b0;
    commit_strobe = 1'b0;
  end
  // every level held 4 cycles: the port needs 3 to see it
  task automatic put_bit(input logic b);
    @(posedge aclk);
    shift_data <= b;
    repeat (4) @(posedge aclk);
    shift_clock <= 1'b1;
    repeat (4) @(posedge aclk);
    shift_clock <= 1'b0;
  endtask
  // commit held high: every shift clock also reloads the dividers
  task automatic flow(input logic [12:0] frame);
    @(posedge aclk);
    commit_strobe <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int i = 12; i >= 0; i--) put_bit(frame[i]);
    repeat (4) @(posedge aclk);
    shift_data <= 1'b0;
    repeat (4) @(posedge aclk);
    commit_strobe <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic send(input logic [12:0] frame, input logic commit);
    for (int i = 12; i >= 0; i--) put_bit(frame[i]);
    repeat (4) @(posedge aclk);
    // released data pin falls to its pulldown level
    shift_data <= 1'b0;
    if (commit) begin
      repeat (4) @(posedge aclk);
      commit_strobe <= 1'b1;
      repeat (8) @(posedge aclk);
      commit_strobe <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ==== bench/synth_divider_program_port_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module synth_divider_program_port_test;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, output_ratio_bits;
  logic [8:0]  feedback_ratio_bits;
  logic        parallel_latch_strobe_low, shift_clock, shift_data, commit_strobe;
  logic        master_divider_reset, ref_select, ref_diff_clock, ref_test_clock;
  logic        fout, fout_n, fout_half, fout_half_n, monitor_out;
  int          errors, checked, rc, f, h, m, hi;

  synth_divider_program_port i_synth_divider_program_port (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .parallel_latch_strobe_low, .feedback_ratio_bits,
    .output_ratio_bits, .shift_clock, .shift_data, .commit_strobe,
    .master_divider_reset, .ref_select, .ref_diff_clock, .ref_test_clock, .fout,
    .fout_n, .fout_half, .fout_half_n, .monitor_out
  );
  config_controller i_config_controller (.aclk, .shift_clock, .shift_data, .commit_strobe);

  // ==========================================================
  // clocks: test reference 80 cycles, differential 160
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    rc <= rc + 1;
    if (rc % 40 == 39) ref_test_clock <= ~ref_test_clock;
    if (rc % 80 == 79) ref_diff_clock <= ~ref_diff_clock;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", s, exp, seen);
    end
  endtask
  // rates come from a digital vco stand-in, so edge counts may slip
  task automatic chkn(input string s, input int seen, input int exp, input int tol);
    chk(s, (seen >= exp - tol && seen <= exp + tol) ? 32'(exp) : 32'(seen), 32'(exp));
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    if (n >= 40) begin
      errors++;
      stop_test;
    end
    chk("bresp", 32'(bresp), 32'(er));
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    if (n >= 40) begin
      errors++;
      stop_test;
    end
    chk("rdata", rdata, ed);
    chk("rresp", 32'(rresp), 32'(er));
  endtask
  task automatic meas;
    logic pf, ph, pm;
    repeat (400) @(posedge aclk);
    {f, h, m, hi} = '0;
    pf = fout;
    ph = fout_half;
    pm = monitor_out;
    repeat (800) begin
      @(posedge aclk);
      f += int'(fout === 1'b1 && pf === 1'b0);
      h += int'(fout_half === 1'b1 && ph === 1'b0);
      m += int'(monitor_out === 1'b1 && pm === 1'b0);
      hi += int'(fout === 1'b1);
      pf = fout;
      ph = fout_half;
      pm = monitor_out;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic s_parallel;
    repeat (8) @(posedge aclk);
    axr(8'h00, 32'h0000_0214, 2'h0);
    axr(8'h08, 32'h0000_0002, 2'h0);
    meas;
    chkn("fout rises", f, 100, 2);
    chkn("half rises", h, 50, 2);
    chkn("fout high", hi, 400, 8);
    chk("monitor rises", 32'(m), 32'h0);
    ref_select <= 1'b1;
    meas;
    chkn("diff rises", f, 50, 2);
    ref_select <= 1'b0;
  endtask
  task automatic s_strobe;
    parallel_latch_strobe_low <= 1'b1;
    repeat (8) @(posedge aclk);
    feedback_ratio_bits <= 9'h00C;
    output_ratio_bits <= 2'h2;
    repeat (8) @(posedge aclk);
    axr(8'h00, 32'h0000_0214, 2'h0);
    axr(8'h08, 32'h0000_0003, 2'h0);
  endtask
  task automatic s_serial;
    logic [12:0] fr;
    for (int c = 0; c < 4; c++) begin
      fr = {c[1:0], 2'h1, 9'h014};
      i_config_controller.send(fr, 1'b1);
      axr(8'h00, 32'(fr), 2'h0);
      fork
        meas;
        if (c == 1) begin
          repeat (450) @(posedge aclk);
          i_config_controller.send(13'h1555, 1'b0);
        end
      join
      chkn("monitor rises", m, (c == 1) ? 7 : (c == 2) ? 10 : (c == 3) ? 50 : 0, 1);
    end
    // shifting alone must leave the latched ratios alone
    i_config_controller.send(13'h01FF, 1'b0);
    axr(8'h00, 32'h0000_1A14, 2'h0);
    i_config_controller.send({2'h3, 2'h2, 9'h01C}, 1'b1);
    axr(8'h08, 32'h0000_0003, 2'h0);
    meas;
    chkn("fout rises", f, 70, 2);
    i_config_controller.send({2'h3, 2'h2, 9'h009}, 1'b1);
    axr(8'h08, 32'h0000_0001, 2'h0);
  endtask
  task automatic s_resets;
    master_divider_reset <= 1'b1;
    meas;
    chk("fout rises", 32'(f), 32'h0);
    chk("outputs", 32'({fout, fout_n, fout_half, fout_half_n}), 32'h5);
    axr(8'h00, 32'h0000_1C09, 2'h0);
    master_divider_reset <= 1'b0;
    axw(8'h04, 32'h1, 2'h0);
    axr(8'h04, 32'h1, 2'h0);
    meas;
    chk("soft rises", 32'(f), 32'h0);
    axw(8'h04, 32'h0, 2'h0);
    axw(8'h0C, 32'h1, 2'h2);
    axw(8'h00, 32'h1, 2'h2);
    axr(8'h0C, 32'h0, 2'h2);
    i_config_controller.flow({2'h3, 2'h1, 9'h012});
    axr(8'h00, 32'h0000_1A12, 2'h0);
  endtask
  task automatic s_back;
    parallel_latch_strobe_low <= 1'b0;
    repeat (8) @(posedge aclk);
    axr(8'h00, 32'h0000_1C0C, 2'h0);
    meas;
    chk("monitor rises", 32'(m), 32'h0);
  endtask

  initial begin
    errors = 0;
    checked = 0;
    rc = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, awprot, arprot} = '0;
    {master_divider_reset, ref_select, ref_diff_clock, ref_test_clock} = '0;
    parallel_latch_strobe_low = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    feedback_ratio_bits = 9'h014;
    output_ratio_bits = 2'h1;
    repeat (2) @(posedge aclk);
    chk("idle outputs", 32'({fout, fout_n, fout_half, fout_half_n, monitor_out}), 32'hA);
    aresetn <= 1'b1;
    s_parallel;
    s_strobe;
    s_serial;
    s_resets;
    s_back;
    stop_test;
  end
endmodule
`default_nettype wire

// ==== logic/rate_multiplier.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// digital stand-in for the vco: multiplier ticks per reference period
module rate_multiplier #(
  parameter int PERIOD_W = 16,
  parameter int MUL_W    = 9
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // reference and ratio
  input  wire logic             ref_edge,
  input  wire logic [MUL_W-1:0] multiplier,
  // tick out
  output logic                  vco_tick
);
  typedef struct packed {
    logic [PERIOD_W-1:0] count;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] acc;
    logic                tick;
  } mul_state_type;

  mul_state_type q, n;

  // at most one tick per aclk: fin * multiplier must stay below aclk
  always_comb begin
    logic [PERIOD_W:0] sum;
    sum = '0;
    n = q;
    n.tick = 1'b0;
    if (ref_edge) begin
      n.period = PERIOD_W'(q.count + 1'b1);
      n.count  = '0;
    end else if (q.count != '1) begin
      n.count = PERIOD_W'(q.count + 1'b1);
    end
    if (q.period != '0) begin
      sum = {1'b0, q.acc} + (PERIOD_W + 1)'(multiplier);
      if (sum >= {1'b0, q.period}) begin
        n.acc  = PERIOD_W'(sum - {1'b0, q.period});
        n.tick = 1'b1;
      end else begin
        n.acc = PERIOD_W'(sum);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign vco_tick = q.tick;
endmodule
`default_nettype wire

// ==== logic/synth_divider_consts.svh ====
`ifndef SYNTH_DIVIDER_CONSTS_SVH
`define SYNTH_DIVIDER_CONSTS_SVH
// ==========================================================
// register map (byte addresses)
`define RATIO_OFFSET        8'h00
`define CTRL_OFFSET         8'h04
`define STATUS_OFFSET       8'h08
`define CTRL_SOFT_RESET_BIT 0
`define STATUS_SERIAL_BIT   0
`define STATUS_RANGE_BIT    1
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
// ==========================================================
// serial frame layout, msb first
`define FRAME_BITS          13
`define TSEL_LSB            11
`define OUTSEL_LSB          9
// ==========================================================
// feedback values that lock with a 25 MHz reference
`define FB_LOCK_MIN         9'h00A
`define FB_LOCK_MAX         9'h01C
`endif

// ==== logic/synth_divider_pkg.sv ====
`default_nettype none
// ==========================================================
// shared state types
package synth_divider_pkg;
  `include "synth_divider_consts.svh"

  typedef struct packed {
    logic [1:0]  pl_s;
    logic [1:0]  sl_s;
    logic [1:0]  sck_s;
    logic [1:0]  sdat_s;
    logic [1:0]  mr_s;
    logic [1:0]  refsel_s;
    logic [1:0]  refd_s;
    logic [1:0]  reft_s;
    logic [8:0]  pfb_s1;
    logic [8:0]  pfb_s2;
    logic [1:0]  pout_s1;
    logic [1:0]  pout_s2;
    logic        sl_d;
    logic        sck_d;
    logic        ref_d;
    logic [12:0] shift;
    logic [8:0]  fb;
    logic [1:0]  outsel;
    logic [1:0]  tsel;
    logic        soft_reset;
    logic        fout;
    logic        fout_n;
    logic        half;
    logic        half_n;
    logic        monitor;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } top_state_type;
endpackage
`default_nettype wire

// ==== logic/synth_divider_program_port.sv ====
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "synth_divider_consts.svh"
// What this block does
// - parallel strobe low passes ratio pins straight to both dividers
// - strobe rising edge keeps parallel values until strobe low or serial event
// - monitor output is low whenever in parallel mode
// - strobe held low from power-up makes strapped ratio pins the default
// - vco rate is reference rate times feedback value
// - main output rate is vco rate over output divide value, except divide 1 (output select 00) gives half the vco rate
// - serial mode shifts one data bit per shift clock rising edge
// - commit strobe rising edge moves shift register into dividers
// - commit strobe falling edge latches divider values
// - commit held high passes shifted data to dividers each shift clock
// - serial frame carries feedback, output and test-select bits
// - test-select 00 low, 01 serial data, 10 feedback, 11 half-rate
// - output divider gives 50 percent duty cycle
// - master reset clears dividers, true outputs low, loaded values kept
// - reference select high picks differential clock, low test clock
module synth_divider_program_port
  import synth_divider_pkg::*;
#(
  parameter logic [31:0] OUT_DIVIDE_TABLE = 32'h0804_0201,
  parameter int          PERIOD_W         = 16
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // parallel programming pins
  input  wire logic        parallel_latch_strobe_low,
  input  wire logic [8:0]  feedback_ratio_bits,
  input  wire logic [1:0]  output_ratio_bits,
  // serial programming pins
  input  wire logic        shift_clock,
  input  wire logic        shift_data,
  input  wire logic        commit_strobe,
  // reset and reference pins
  input  wire logic        master_divider_reset,
  input  wire logic        ref_select,
  input  wire logic        ref_diff_clock,
  input  wire logic        ref_test_clock,
  // clock outputs
  output logic             fout,
  output logic             fout_n,
  output logic             fout_half,
  output logic             fout_half_n,
  output logic             monitor_out
);
  top_state_type q, n;

  logic       sck_rise;
  logic       sl_rise;
  logic       ref_level;
  logic       ref_edge;
  logic       clr;
  logic       vco_tick;
  logic       fb_level;
  logic       main_level;
  logic       main_rise;
  logic       half_level;
  logic [8:0] out_divide;

  // ==========================================================
  // helpers
  function automatic logic [8:0] divide_for(input logic [1:0] sel);
    return {1'b0, OUT_DIVIDE_TABLE[{sel, 3'b000} +: 8]};
  endfunction

  function automatic logic in_lock_range(input logic [8:0] m);
    return (m >= `FB_LOCK_MIN) && (m <= `FB_LOCK_MAX);
  endfunction

  assign sck_rise   = q.sck_s[1] && !q.sck_d;
  assign sl_rise    = q.sl_s[1] && !q.sl_d;
  assign ref_level  = q.refsel_s[1] ? q.refd_s[1] : q.reft_s[1];
  assign ref_edge   = ref_level && !q.ref_d;
  assign clr        = q.mr_s[1] || q.soft_reset;
  assign out_divide = divide_for(q.outsel);

  // ==========================================================
  // vco model and dividers
  rate_multiplier #(
    .PERIOD_W (PERIOD_W),
    .MUL_W    (9)
  ) vco_model (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ref_edge   (ref_edge),
    .multiplier (q.fb),
    .vco_tick   (vco_tick)
  );

  tick_divider #(.W(9)) feedback_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (clr),
    .tick    (vco_tick),
    .divisor (q.fb),
    .level   (fb_level),
    .rise    ()
  );

  tick_divider #(.W(9)) main_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (clr),
    .tick    (vco_tick),
    .divisor (out_divide),
    .level   (main_level),
    .rise    (main_rise)
  );

  tick_divider #(.W(9)) half_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (clr),
    .tick    (main_rise),
    .divisor (9'h002),
    .level   (half_level),
    .rise    ()
  );

  // ==========================================================
  // next state
  always_comb begin
    logic       aw_hs;
    logic       w_hs;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    aw_hs = awvalid && q.awready;
    w_hs  = wvalid && q.wready;
    addr  = aw_hs ? awaddr : q.waddr;
    data  = w_hs ? wdata : q.wdata;
    strb  = w_hs ? wstrb : q.wstrb;
    n = q;
    // pins are asynchronous; first stage feeds only the second
    n.pl_s     = {q.pl_s[0], parallel_latch_strobe_low};
    n.sl_s     = {q.sl_s[0], commit_strobe};
    n.sck_s    = {q.sck_s[0], shift_clock};
    n.sdat_s   = {q.sdat_s[0], shift_data};
    n.mr_s     = {q.mr_s[0], master_divider_reset};
    n.refsel_s = {q.refsel_s[0], ref_select};
    n.refd_s   = {q.refd_s[0], ref_diff_clock};
    n.reft_s   = {q.reft_s[0], ref_test_clock};
    n.pfb_s1   = feedback_ratio_bits;
    n.pfb_s2   = q.pfb_s1;
    n.pout_s1  = output_ratio_bits;
    n.pout_s2  = q.pout_s1;
    n.sl_d     = q.sl_s[1];
    n.sck_d    = q.sck_s[1];
    n.ref_d    = ref_level;

    // ratio programming; master reset leaves these untouched
    if (!q.pl_s[1]) begin
      n.fb     = q.pfb_s2;
      n.outsel = q.pout_s2;
    end else begin
      if (sck_rise) begin
        n.shift = {q.shift[`FRAME_BITS-2:0], q.sdat_s[1]};
      end
      if (sl_rise) begin
        n.tsel   = q.shift[`TSEL_LSB +: 2];
        n.outsel = q.shift[`OUTSEL_LSB +: 2];
        n.fb     = q.shift[8:0];
      end else if (q.sl_s[1] && q.sl_d && sck_rise) begin
        n.tsel   = n.shift[`TSEL_LSB +: 2];
        n.outsel = n.shift[`OUTSEL_LSB +: 2];
        n.fb     = n.shift[8:0];
      end
      // otherwise held: after strobe rise and after commit fall
    end

    // monitor mux, forced low in parallel mode
    if (!q.pl_s[1]) begin
      n.monitor = 1'b0;
    end else begin
      unique case (q.tsel)
        2'b00: n.monitor = 1'b0;
        2'b01: n.monitor = q.sdat_s[1];
        2'b10: n.monitor = fb_level;
        2'b11: n.monitor = half_level;
      endcase
    end

    n.fout   = !clr && main_level;
    n.fout_n = clr || !main_level;
    n.half   = !clr && half_level;
    n.half_n = clr || !half_level;

    // axi write: address and data taken in either order
    if (aw_hs) begin
      n.awready = 1'b0;
      n.aw_got  = 1'b1;
      n.waddr   = awaddr;
    end
    if (w_hs) begin
      n.wready = 1'b0;
      n.w_got  = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    if ((q.aw_got || aw_hs) && (q.w_got || w_hs)) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      if (addr == `CTRL_OFFSET) begin
        n.bresp = `RESP_OKAY;
        if (strb[0]) n.soft_reset = data[`CTRL_SOFT_RESET_BIT];
      end else begin
        n.bresp = `RESP_SLVERR;
      end
    end
    if (q.bvalid && bready) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    // axi read
    if (arvalid && q.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = `RESP_OKAY;
      n.rdata   = 32'h0000_0000;
      unique case (araddr)
        `RATIO_OFFSET:  n.rdata[12:0] = {q.tsel, q.outsel, q.fb};
        `CTRL_OFFSET:   n.rdata[`CTRL_SOFT_RESET_BIT] = q.soft_reset;
        `STATUS_OFFSET: begin
          n.rdata[`STATUS_SERIAL_BIT] = q.pl_s[1];
          n.rdata[`STATUS_RANGE_BIT]  = in_lock_range(q.fb);
        end
        default:        n.rresp = `RESP_SLVERR;
      endcase
    end
    if (q.rvalid && rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
      q.fout_n  <= 1'b1;
      q.half_n  <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // outputs
  assign awready     = q.awready;
  assign wready      = q.wready;
  assign bvalid      = q.bvalid;
  assign bresp       = q.bresp;
  assign arready     = q.arready;
  assign rvalid      = q.rvalid;
  assign rdata       = q.rdata;
  assign rresp       = q.rresp;
  assign fout        = q.fout;
  assign fout_n      = q.fout_n;
  assign fout_half   = q.half;
  assign fout_half_n = q.half_n;
  assign monitor_out = q.monitor;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence parallel_s;
    !q.pl_s[1];
  endsequence

  sequence commit_s;
    q.pl_s[1] && sl_rise;
  endsequence

  sequence write_pair_s;
    (q.aw_got || (awvalid && q.awready)) && (q.w_got || (wvalid && q.wready));
  endsequence

  parallel_pass_a: assert property (parallel_s |=> q.fb == $past(q.pfb_s2))
    else $error("feedback not following parallel pins");
  parallel_hold_a: assert property (q.pl_s[1] && !sck_rise && !sl_rise |=> $stable(q.fb))
    else $error("divider value changed without a load event");
  monitor_low_a: assert property (parallel_s ##1 parallel_s |=> !q.monitor)
    else $error("monitor not low in parallel mode");
  shift_in_a: assert property (q.pl_s[1] && sck_rise |=>
      q.shift == {$past(q.shift[11:0]), $past(q.sdat_s[1])})
    else $error("serial bit not shifted in");
  commit_load_a: assert property (commit_s |=>
      q.fb == $past(q.shift[8:0]) && q.tsel == $past(q.shift[12:11]))
    else $error("commit did not load shift register");
  flow_through_a: assert property (q.pl_s[1] && q.sl_s[1] && q.sl_d && sck_rise |=>
      q.fb == {$past(q.shift[7:0]), $past(q.sdat_s[1])})
    else $error("held commit did not pass data through");
  monitor_sel_a: assert property (q.pl_s[1] && q.tsel == 2'b10 |=>
      q.monitor == $past(fb_level))
    else $error("monitor not showing feedback divider");
  reset_out_a: assert property (clr ##1 clr |=>
      !q.fout && q.fout_n && !q.half && q.half_n)
    else $error("outputs not forced by master reset");
  write_resp_a: assert property (write_pair_s |=> q.bvalid && !q.awready && !q.wready)
    else $error("write response missing");
endmodule
`default_nettype wire

// ==== logic/tick_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// divides a tick stream, output high half and low half of the count
module tick_divider #(
  parameter int W = 9
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // control
  input  wire logic         clr,
  input  wire logic         tick,
  input  wire logic [W-1:0] divisor,
  // output
  output logic              level,
  output logic              rise
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         level;
    logic         rise;
  } div_state_type;

  div_state_type q, n;

  // odd divisors above 1 give one tick more high than low
  always_comb begin
    logic [W-1:0] low_len;
    logic [W-1:0] high_len;
    low_len  = divisor >> 1;
    high_len = W'(divisor - low_len);
    if (low_len == '0) low_len = W'(1);
    if (high_len == '0) high_len = W'(1);
    n = q;
    n.rise = 1'b0;
    if (clr) begin
      n = '0;
    end else if (tick) begin
      if (W'(q.count + 1'b1) >= (q.level ? high_len : low_len)) begin
        n.count = '0;
        n.level = !q.level;
        n.rise  = !q.level;
      end else begin
        n.count = W'(q.count + 1'b1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign level = q.level;
  assign rise  = q.rise;
endmodule
`default_nettype wire
